/* File: rtl/sdadc_defs.svh */
/*
 * Constants of the converter serial port: command codes, field layout,
 * timing figures and reset values.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SDADC_DEFS_SVH
`define SDADC_DEFS_SVH

`define SDADC_CMD_READ 8'h0_001
`define SDADC_CMD_READ_CONT 8'h0_003
`define SDADC_CMD_STOP_CONT 8'h0_00F
`define SDADC_CMD_REG_READ_BASE 8'h0_010
`define SDADC_CMD_REG_WRITE_BASE 8'h0_050
`define SDADC_CMD_OP_MASK 8'h0_0F0
`define SDADC_REG_IDX_MSB 2
`define SDADC_NUM_REGS 4
`define SDADC_REG_GAIN 2'h0
`define SDADC_REG_RATIO 2'h1
`define SDADC_REG_SCAN 2'h2
`define SDADC_REG_STATUS 2'h3
`define SDADC_GAIN_RESET 3'h0
`define SDADC_RATIO_RESET 3'h0
`define SDADC_SCAN_RESET 3'h0
`define SDADC_RESULT_BITS 24
`define SDADC_BYTE_BITS 8
`define SDADC_CLK_PERIOD_NS 100

`endif

/* File: rtl/sdadc_pkg.sv */
/*
 * Types shared by the converter serial port.
 * Assumes the constant header sits on the include path.
 */
package sdadc_pkg;
   `include "sdadc_defs.svh"

   typedef enum logic [2:0] {
      SDADC_CMD = 3'b000,
      SDADC_DATA = 3'b001,
      SDADC_REG_RD = 3'b010,
      SDADC_REG_WR = 3'b011,
      SDADC_IDLE = 3'b100
   } sdadc_phase_e;

   typedef struct packed {
      logic [2:0] gain_log2;
      logic [2:0] ratio_sel;
      logic scan_all;
      logic [1:0] channel;
   } sdadc_cfg_s;

   typedef struct packed {
      logic [23:0] value;
      logic [1:0] channel;
      logic over_range;
   } sdadc_result_s;
endpackage

/* File: rtl/sdadc_pin_sync.sv */
/*
 * Two-flop synchroniser for pins arriving from outside the core clock.
 * Assumes an asynchronous active-low reset and a constant reset level.
 */
`timescale 1ns/1ps
module sdadc_pin_sync import sdadc_pkg::*; #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic pin,
   output logic sync
);
   logic meta;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta <= RESET_VAL;
         sync <= RESET_VAL;
      end else begin
         meta <= pin;
         sync <= meta;
      end
   end
endmodule

/* File: rtl/sdadc_serial_port.sv */
/*
 * Serial port of a four-channel 24-bit sigma-delta converter: command
 * decoder, result shifter, small configuration file, ready and over-range.
 * Assumes the host keeps the link timing limits and that the filter side
 * presents each result with a one-cycle valid pulse.
 */
`timescale 1ns/1ps
`include "sdadc_defs.svh"
module sdadc_serial_port import sdadc_pkg::*; #(
   parameter int RESULT_BITS = `SDADC_RESULT_BITS
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire sdadc_result_s result_in,
   input wire logic result_valid,
   output logic result_ready_n,
   output logic over_range_flag,
   output sdadc_cfg_s cfg,
   output logic cmd_read_result_continuous
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic sel_n_s, sclk_s, sdi_s, sclk_d;

   sdadc_pin_sync #(.RESET_VAL(1'b1)) u_sel (
      .core_clk(core_clk), .rstn(rstn), .pin(sel_n), .sync(sel_n_s));
   sdadc_pin_sync #(.RESET_VAL(1'b0)) u_sclk (
      .core_clk(core_clk), .rstn(rstn), .pin(sclk), .sync(sclk_s));
   sdadc_pin_sync #(.RESET_VAL(1'b0)) u_sdi (
      .core_clk(core_clk), .rstn(rstn), .pin(sdi), .sync(sdi_s));

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   // Edges are only honoured inside a frame
   logic active, rise, fall;
   assign active = !sel_n_s;
   assign rise = active && sclk_s && !sclk_d;
   assign fall = active && !sclk_s && sclk_d;

   // ****************************************
   // Receive shifter and byte framing
   // ****************************************
   logic [7:0] rx_shift;
   logic [2:0] bit_cnt;
   logic byte_done;
   logic [7:0] rx_byte;
   assign rx_byte = {rx_shift[6:0], sdi_s};
   assign byte_done = rise && (bit_cnt == 3'h7);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_shift <= 8'h0_000;
         bit_cnt <= 3'h0;
      end else if (!active) begin
         bit_cnt <= 3'h0;
      end else if (rise) begin
         rx_shift <= rx_byte;
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // ****************************************
   // Command decoder
   // ****************************************
   sdadc_phase_e phase;
   logic [1:0] reg_idx;
   logic [4:0] bytes_left;
   logic [2:0] cfg_regs [`SDADC_NUM_REGS];
   logic load_result, load_reg;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase <= SDADC_CMD;
         reg_idx <= 2'h0;
         bytes_left <= 5'h0_000;
         cmd_read_result_continuous <= 1'b0;
      end else if (!active) begin
         phase <= SDADC_CMD;
      end else if (byte_done) begin
         case (phase)
            SDADC_CMD: begin
               reg_idx <= rx_byte[1:0];
               if (rx_byte == `SDADC_CMD_READ) begin
                  phase <= SDADC_DATA;
                  bytes_left <= 5'h0_003;
               end else if (rx_byte == `SDADC_CMD_READ_CONT) begin
                  cmd_read_result_continuous <= 1'b1;
               end else if (rx_byte == `SDADC_CMD_STOP_CONT) begin
                  cmd_read_result_continuous <= 1'b0;
               end else if ((rx_byte & `SDADC_CMD_OP_MASK) == `SDADC_CMD_REG_READ_BASE) begin
                  phase <= SDADC_REG_RD;
               end else if ((rx_byte & `SDADC_CMD_OP_MASK) == `SDADC_CMD_REG_WRITE_BASE) begin
                  phase <= SDADC_REG_WR;
               end
            end
            SDADC_DATA: begin
               bytes_left <= bytes_left - 5'h0_001;
               if (bytes_left == 5'h0_001) begin
                  phase <= SDADC_CMD;
               end
            end
            SDADC_REG_RD: phase <= SDADC_CMD;
            SDADC_REG_WR: phase <= SDADC_CMD;
            default: phase <= SDADC_CMD;
         endcase
      end
   end

   assign load_result = byte_done && (phase == SDADC_CMD) && (rx_byte == `SDADC_CMD_READ);
   assign load_reg = byte_done && (phase == SDADC_CMD) &&
      ((rx_byte & `SDADC_CMD_OP_MASK) == `SDADC_CMD_REG_READ_BASE);

   // ****************************************
   // Configuration registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_regs[0] <= `SDADC_GAIN_RESET;
         cfg_regs[1] <= `SDADC_RATIO_RESET;
         cfg_regs[2] <= `SDADC_SCAN_RESET;
         cfg_regs[3] <= 3'h0;
      end else if (byte_done && phase == SDADC_REG_WR && reg_idx != `SDADC_REG_STATUS) begin
         cfg_regs[reg_idx] <= rx_byte[2:0];
      end
   end

   // Channel pointer advances per result in scan mode
   logic [1:0] scan_ch;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         scan_ch <= 2'h0;
      end else if (result_valid && cfg_regs[2][2]) begin
         scan_ch <= scan_ch + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cfg <= '0;
      end else begin
         cfg.gain_log2 <= cfg_regs[0];
         cfg.ratio_sel <= cfg_regs[1];
         cfg.scan_all <= cfg_regs[2][2];
         cfg.channel <= cfg_regs[2][2] ? scan_ch : cfg_regs[2][1:0];
      end
   end

   // ****************************************
   // Result latch, ready and over-range
   // ****************************************
   logic [RESULT_BITS-1:0] result_word;
   logic cont_load;
   assign cont_load = cmd_read_result_continuous && !result_ready_n && phase == SDADC_CMD &&
      active && bit_cnt == 3'h0 && rise;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         result_word <= '0;
         over_range_flag <= 1'b0;
      end else if (result_valid) begin
         result_word <= result_in.value;
         over_range_flag <= result_in.over_range;
      end
   end

   // New result wins over a read in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         result_ready_n <= 1'b1;
      end else if (result_valid) begin
         result_ready_n <= 1'b0;
      end else if (load_result || (phase == SDADC_DATA && bytes_left == 5'h0_001 && byte_done)) begin
         result_ready_n <= 1'b1;
      end
   end

   // ****************************************
   // Transmit shifter
   // ****************************************
   logic [RESULT_BITS-1:0] tx_shift;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_shift <= '0;
         sdo <= 1'b0;
      end else if (load_result) begin
         tx_shift <= result_word;
      end else if (load_reg) begin
         tx_shift <= {cfg_regs[rx_byte[1:0]], {(RESULT_BITS-3){1'b0}}};
      end else if (fall) begin
         sdo <= tx_shift[RESULT_BITS-1];
         tx_shift <= {tx_shift[RESULT_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= active;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   oe_released_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sel_n_s |=> !sdo_oe) else $error("output driven with select high");
   sdo_on_fall_a: assert property (@(posedge core_clk) disable iff (!rstn)
      ($changed(sdo)) |-> $past(fall)) else $error("output changed off a falling edge");
   ready_on_result_a: assert property (@(posedge core_clk) disable iff (!rstn)
      result_valid |=> !result_ready_n) else $error("ready not asserted");
   over_range_a: assert property (@(posedge core_clk) disable iff (!rstn)
      result_valid |=> over_range_flag == $past(result_in.over_range))
      else $error("over-range not reported");
   idle_bits_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sel_n_s |=> bit_cnt == 3'h0) else $error("bit count ran outside frame");
   rx_sample_a: assert property (@(posedge core_clk) disable iff (!rstn)
      rise |=> rx_shift[0] == $past(sdi_s)) else $error("input not sampled on rise");
   ratio_cfg_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (byte_done && phase == SDADC_REG_WR && reg_idx == `SDADC_REG_RATIO) |=> ##1
      cfg.ratio_sel == $past(rx_byte[2:0], 2)) else $error("ratio not applied");
   load_word_a: assert property (@(posedge core_clk) disable iff (!rstn)
      load_result |=> tx_shift == $past(result_word)) else $error("result not loaded");
   unused_cont_a: assert property (@(posedge core_clk) disable iff (!rstn)
      (result_valid && cfg_regs[2][2] && !cont_load) |=> scan_ch == $past(scan_ch) + 2'h1)
      else $error("scan did not advance");
endmodule

/* File: tb/sdadc_host_model.sv */
/*
 * Host controller model that drives the converter serial port pins.
 * Assumes a 100 ns core clock; the bench calls its tasks.
 */
`timescale 1ns/1ps
module sdadc_host_model (
   input wire logic core_clk,
   input wire logic sdo,
   output logic sel_n,
   output logic sclk,
   output logic sdi
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // Extra settling because select crosses two flops in the device
   task automatic frame_edge(input logic v);
      @(posedge core_clk) sel_n <= v;
      repeat (5) @(posedge core_clk);
   endtask

   // Serial clock idles low, 800 ns period, stands still between bytes
   task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
      @(posedge core_clk);
      for (int i = 7; i >= 0; i--) begin
         sdi <= tx[i];
         repeat (4) @(posedge core_clk);
         sclk <= 1'b1;
         rx[i] = sdo;
         repeat (4) @(posedge core_clk);
         sclk <= 1'b0;
      end
      // Gap also covers command spacing and the continuous-read wait
      repeat (52) @(posedge core_clk);
      sdi <= ~sdi;
   endtask
endmodule

/* File: tb/sigma_delta_adc_serial_port_bench.sv */
/*
 * Self-checking bench for the converter serial port.
 * Assumes the host model drives the pins and the bench plays the filter.
 */
`timescale 1ns/1ps
module sigma_delta_adc_serial_port_bench import sdadc_pkg::*;;
   logic core_clk, rstn, result_valid, sel_n, sclk, sdi, sdo, sdo_oe;
   logic result_ready_n, over_range_flag, cont;
   logic sdo_pin;
   sdadc_result_s result_in;
   sdadc_cfg_s cfg;
   logic [7:0] rx;
   logic [23:0] word;
   int errors, cmp_count;
   // ****************************************
   // Rows: register, value written, expected configuration
   // ****************************************
   logic [13:0] rows [8] = '{{2'h0, 3'h7, 9'h1C0}, {2'h1, 3'h5, 9'h1E8},
      {2'h2, 3'h6, 9'h1EC}, {2'h2, 3'h1, 9'h1E9}, {2'h0, 3'h0, 9'h029},
      {2'h0, 3'h3, 9'h0E9}, {2'h1, 3'h2, 9'h0D1}, {2'h3, 3'h7, 9'h0D1}};

   sdadc_serial_port uut (.core_clk(core_clk), .rstn(rstn), .sel_n(sel_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .result_in(result_in),
      .result_valid(result_valid), .result_ready_n(result_ready_n),
      .over_range_flag(over_range_flag), .cfg(cfg), .cmd_read_result_continuous(cont));
   // Undriven output shows the inverse of its last value, so the host cannot read stale data
   assign sdo_pin = sdo_oe ? sdo : ~sdo;
   sdadc_host_model host (.core_clk(core_clk), .sdo(sdo_pin), .sel_n(sel_n), .sclk(sclk),
      .sdi(sdi));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic frame(input logic [7:0] cmd, input logic [7:0] arg, input int n);
      host.frame_edge(1'b0);
      chk("sdo_oe in frame", 1'h1, sdo_oe);
      host.xbyte(cmd, rx);
      for (int i = 0; i < n; i++) begin
         host.xbyte(arg, rx);
         word = {word[15:0], rx};
      end
      host.frame_edge(1'b1);
      chk("sdo_oe idle", 1'h0, sdo_oe);
   endtask

   // Filter side: one-cycle valid, then a bounded wait for ready
   task automatic post(input logic [23:0] v, input logic o);
      @(posedge core_clk) result_in <= {v, 2'h1, o};
      result_valid <= 1'b1;
      @(posedge core_clk) result_valid <= 1'b0;
      for (int i = 0; i < 20 && result_ready_n !== 1'b0; i++)
         @(posedge core_clk);
      chk("ready_n", 1'h0, result_ready_n);
      if (result_ready_n !== 1'b0) begin
         complete_run();
      end else begin
         chk("over_range", o, over_range_flag);
      end
   endtask

   initial begin
      rstn = 1'b0;
      result_valid = 1'b0;
      result_in = '0;
      repeat (16) @(posedge core_clk);
      chk("reset ready_n", 1'h1, result_ready_n);
      chk("reset oe", 1'h0, sdo_oe);
      chk("reset cfg", 9'h000, cfg);
      chk("reset over_range", 1'h0, over_range_flag);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (int r = 0; r < 8; r++) begin
         frame({4'h5, 2'h0, rows[r][13:12]}, {5'h00, rows[r][11:9]}, 1);
         chk("cfg", rows[r][8:0], cfg);
         if (rows[r][13:12] != 2'h3) begin
            frame({4'h1, 2'h0, rows[r][13:12]}, 8'h00, 1);
            chk("readback", rows[r][11:9], rx[7:5]);
         end
      end
      // Edges without select must not reach the decoder
      host.xbyte(8'h50, rx);
      host.xbyte(8'h00, rx);
      chk("cfg unselected", 9'h0D1, cfg);
      post(24'h5A_C3A5, 1'b1);
      // The read command itself releases ready, even when the frame is cut short
      frame(8'h01, 8'h00, 1);
      chk("ready after abort", 1'h1, result_ready_n);
      frame(8'h01, 8'h00, 3);
      chk("result", 24'h5A_C3A5, word);
      chk("ready cleared", 1'h1, result_ready_n);
      frame(8'h03, 8'h00, 0);
      chk("continuous on", 1'h1, cont);
      post(24'h80_0001, 1'b0);
      frame(8'h01, 8'h00, 3);
      chk("result two", 24'h80_0001, word);
      frame(8'h0F, 8'h00, 0);
      chk("continuous off", 1'h0, cont);
      // Scan mode: the reported channel steps with each new result
      frame(8'h52, 8'h04, 1);
      chk("scan cfg", 9'h0D4, cfg);
      post(24'h00_0010, 1'b0);
      repeat (2) @(posedge core_clk);
      chk("scan step", 9'h0D5, cfg);
      @(posedge core_clk) rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("mid reset cfg", 9'h000, cfg);
      chk("mid reset ready_n", 1'h1, result_ready_n);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("after reset oe", 1'h0, sdo_oe);
      chk("after reset cont", 1'h0, cont);
      frame(8'h51, 8'h05, 1);
      chk("ratio after reset", 9'h028, cfg);
      complete_run();
   end
endmodule
